// ==== src/timer_watchdog_defs.svh ====
// Purpose: bit positions, keys and reset values of the timer/watchdog core
// Assumes: included by every design file that needs a field position
// Notes: definitions only
`ifndef TIMER_WATCHDOG_DEFS_SVH
`define TIMER_WATCHDOG_DEFS_SVH
`define REG_RESET 32'h0000_0000
`define CTL_RUN_LSB 6
`define CTL_PW_LSB 4
`define CTL_STYLE_BIT 3
`define CTL_INV_BIT 1
`define CTL_HI_OFS 16
`define CTL_RUN_MASK 32'h00c0_00c0
`define GLB_REL_LO_BIT 0
`define GLB_REL_HI_BIT 1
`define GLB_MODE_LSB 2
`define GLB_REL_MASK 32'h0000_0003
`define EMU_FREE_BIT 0
`define EMU_SOFT_BIT 1
`define WDC_ARM_BIT 14
`define WDC_KEY_LSB 16
`define KEY_FIRST 16'ha5c6
`define KEY_SECOND 16'hda7e
`endif

// ==== src/timer_watchdog_pkg.sv ====
// Purpose: types shared by the timer/watchdog core and its bench
// Assumes: field positions come from timer_watchdog_defs.svh
// Notes: no constants here besides enum codes
package timer_watchdog_pkg;
  typedef enum logic [1:0] {
    ARR_64 = 2'b00,
    ARR_UNCHAINED = 2'b01,
    ARR_WATCHDOG = 2'b10,
    ARR_CHAINED = 2'b11
  } arrangement_t;
  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_ONCE = 2'b01,
    RUN_CONT = 2'b10,
    RUN_RSVD = 2'b11
  } run_t;
  typedef enum logic [1:0] {
    WD_INITIAL = 2'b00,
    WD_PREACTIVE = 2'b01,
    WD_ACTIVE = 2'b10,
    WD_TIMEOUT = 2'b11
  } wd_state_t;
  typedef enum logic [2:0] {
    SEL_CNT_LO = 3'h0,
    SEL_CNT_HI = 3'h1,
    SEL_PRD_LO = 3'h2,
    SEL_PRD_HI = 3'h3,
    SEL_CTL = 3'h4,
    SEL_GLB = 3'h5,
    SEL_EMU = 3'h6,
    SEL_WDC = 3'h7
  } reg_sel_t;
  typedef struct packed {
    logic en;
    reg_sel_t sel;
    logic [31:0] data;
  } reg_wr_t;
  typedef struct packed {
    logic irqLo;
    logic dmaLo;
    logic irqHi;
    logic dmaHi;
    logic wdIrq;
  } events_t;
endpackage : timer_watchdog_pkg

// ==== src/count_half.sv ====
// Purpose: one 32-bit counter half with clear, load and increment
// Assumes: clear beats load beats increment
// Notes: increment wraps from all ones to zero
`timescale 1ns/100ps
`default_nettype none
module count_half #(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic load,
  input wire logic [W-1:0] loadData,
  input wire logic inc,
  output logic [W-1:0] count_q
);
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      count_q <= '0;
    else if (clr)
      count_q <= '0;
    else if (load)
      count_q <= loadData;
    else if (inc)
      count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule : count_half
`default_nettype wire

// ==== src/pulse_shaper.sv ====
// Purpose: timer output pin shaping, pulse or toggling clock
// Assumes: trig is a one-cycle match strobe
// Notes: pin comes from a flop, so it lags trig by one clock
`timescale 1ns/100ps
`default_nettype none
module pulse_shaper (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic trig,
  input wire logic [1:0] width,
  input wire logic invert,
  input wire logic clockMode,
  output logic pinOut_q
);
  logic [2:0] left_q;
  logic [2:0] left_d;
  logic tgl_q;

  always_comb
  begin
    if (trig)
      left_d = {1'b0, width} + 3'h1;
    else if (left_q != 3'h0)
      left_d = left_q - 3'h1;
    else
      left_d = 3'h0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      left_q <= 3'h0;
    else
      left_q <= left_d;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      tgl_q <= 1'b0;
    else if (trig)
      tgl_q <= ~tgl_q;
  end

  // clock mode ignores width and polarity
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      pinOut_q <= 1'b0;
    else if (clockMode)
      pinOut_q <= tgl_q ^ trig;
    else
      pinOut_q <= (left_d != 3'h0) ^ invert;
  end
endmodule : pulse_shaper
`default_nettype wire

// ==== src/timer_watchdog_core.sv ====
// Purpose: 64-bit timer splittable into two halves, with watchdog mode
// Assumes: psuResetN is glitch-free; writes arrive as one-cycle strobes
// Notes: IS_WATCHDOG selects the instance that owns the watchdog
// What this block does
// - counter above period wraps through zero
// - running timer ignores most register writes
// - watchdog off at reset, needs mode and arm
// - watchdog uses 64-bit count, match resets chip
// - ordered key pair services and clears counter
// - wrong key in active watchdog times out
// - timeout disarms, resets timer, stays till reset
// - only timeout or reset ends active watchdog
// - arm plus first key enters pre-active
// - pre-active accepts control only with valid key
// - second key with arm activates, clears counters
// - from pre-active counters and periods locked, control stays writable
// - output pulse 1-4 clocks, or toggling clock
// - upper output settings ignored in 64/unchained
// - outside watchdog mode, a cleared half-release freezes that half
// - device or power-unit reset restores defaults
// - match raises interrupt and dma per mode
// - debug suspend obeys free and soft bits
// - counts on timer clock, not cpu steps
`timescale 1ns/100ps
`default_nettype none
`include "timer_watchdog_defs.svh"
module timer_watchdog_core #(
  parameter bit IS_WATCHDOG = 1'b1,
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psuResetN,
  input wire timer_watchdog_pkg::reg_wr_t regWr,
  input wire logic debugSuspend,
  output logic [W-1:0] counterLow,
  output logic [W-1:0] counterHigh,
  output timer_watchdog_pkg::wd_state_t wdState,
  output logic watchdogArm,
  output logic systemReset_q,
  output timer_watchdog_pkg::events_t events_q,
  output logic timerOutLow,
  output logic timerOutHigh
);
  logic resetN;
  logic [31:0] ctl_q;
  logic [31:0] glb_q;
  logic [1:0] emu_q;
  logic [W-1:0] prdLo_q;
  logic [W-1:0] prdHi_q;
  logic arm_q;
  logic keySeen_q;
  timer_watchdog_pkg::wd_state_t wdState_q;
  timer_watchdog_pkg::arrangement_t mode;
  timer_watchdog_pkg::run_t runLo;
  timer_watchdog_pkg::run_t runHi;
  logic relLo;
  logic relHi;
  logic gpActive;
  logic wdLocked;
  logic wrCntOk;
  logic [15:0] key;
  logic keyWr;
  logic armNew;
  logic matchLo;
  logic matchHi;
  logic match64;
  logic haltLo;
  logic haltHi;
  logic adv64;
  logic advCh;
  logic advLo;
  logic advHi;
  logic clrLo;
  logic clrHi;
  logic incLo;
  logic incHi;
  logic evLo;
  logic evHi;
  logic wdMode;
  logic wdRun;
  logic wdService;
  logic toEntry;
  logic [1:0] hiWidth;
  logic hiInv;
  logic hiStyle;
  logic hiTrig;
  logic contLo;
  logic contHi;
  logic onceLo_q;
  logic onceHi_q;

  // power-unit reset acts as a full hardware reset
  assign resetN = rstn & psuResetN;

  assign mode = timer_watchdog_pkg::arrangement_t'(glb_q[`GLB_MODE_LSB +: 2]);
  assign runLo = timer_watchdog_pkg::run_t'(ctl_q[`CTL_RUN_LSB +: 2]);
  assign runHi = timer_watchdog_pkg::run_t'(ctl_q[`CTL_HI_OFS + `CTL_RUN_LSB +: 2]);
  assign relLo = glb_q[`GLB_REL_LO_BIT];
  assign relHi = glb_q[`GLB_REL_HI_BIT];
  // watchdog never runs one-shot, so it always restarts at the period
  assign contLo = wdMode || (runLo != timer_watchdog_pkg::RUN_ONCE);
  assign contHi = runHi != timer_watchdog_pkg::RUN_ONCE;
  assign wdMode = IS_WATCHDOG && (mode == timer_watchdog_pkg::ARR_WATCHDOG);
  assign wdRun = wdMode && (wdState_q == timer_watchdog_pkg::WD_ACTIVE) && arm_q;

  // timer counts as active while released and enabled
  assign gpActive = !wdMode && ((relLo && runLo != timer_watchdog_pkg::RUN_OFF)
                    || (relHi && runHi != timer_watchdog_pkg::RUN_OFF));
  assign wdLocked = IS_WATCHDOG && (wdState_q != timer_watchdog_pkg::WD_INITIAL);
  assign wrCntOk = !gpActive && !wdLocked;

  assign key = regWr.data[`WDC_KEY_LSB +: 16];
  assign keyWr = IS_WATCHDOG && regWr.en && (regWr.sel == timer_watchdog_pkg::SEL_WDC);
  assign armNew = regWr.data[`WDC_ARM_BIT];

  assign matchLo = (counterLow == prdLo_q);
  assign matchHi = (counterHigh == prdHi_q);
  assign match64 = matchLo && matchHi;

  // free runs on; soft stops at the period, else at once
  assign haltLo = debugSuspend && !emu_q[`EMU_FREE_BIT]
                  && (!emu_q[`EMU_SOFT_BIT]
                      || (mode == timer_watchdog_pkg::ARR_64 || wdMode ? match64 : matchLo));
  assign haltHi = debugSuspend && !emu_q[`EMU_FREE_BIT]
                  && (!emu_q[`EMU_SOFT_BIT] || matchHi);

  // a cleared release bit only withholds the advance
  // one advance per mclk at most
  // one-shot stops only after its single period event has gone out
  assign adv64 = wdMode ? (wdRun && !haltLo)
                 : (relLo && relHi && runLo != timer_watchdog_pkg::RUN_OFF && !haltLo
                    && !(!contLo && onceLo_q));
  assign advCh = relLo && relHi && runLo != timer_watchdog_pkg::RUN_OFF && !haltLo
                 && !(!contLo && onceLo_q);
  assign advLo = relLo && runLo != timer_watchdog_pkg::RUN_OFF && !haltLo
                 && !(!contLo && onceLo_q);
  assign advHi = relHi && runHi != timer_watchdog_pkg::RUN_OFF && !haltHi
                 && !(!contHi && onceHi_q);

  // ordered pair after first key services the count
  assign wdService = wdRun && keyWr && key == `KEY_SECOND && keySeen_q;
  // match on the joined count, a bad key, both time out
  assign toEntry = wdRun && ((adv64 && match64)
                   || (keyWr && key != `KEY_FIRST && key != `KEY_SECOND));

  always_comb
  begin
    clrLo = 1'b0;
    clrHi = 1'b0;
    incLo = 1'b0;
    incHi = 1'b0;
    evLo = 1'b0;
    evHi = 1'b0;
    unique case (mode)
      timer_watchdog_pkg::ARR_64, timer_watchdog_pkg::ARR_WATCHDOG:
      begin
        // carry through all ones, clear only at the period
        if (adv64)
        begin
          evLo = match64;
          clrLo = match64 && contLo;
          clrHi = match64 && contLo;
          incLo = !match64;
          incHi = !match64 && (&counterLow);
        end
      end
      timer_watchdog_pkg::ARR_CHAINED:
      begin
        // upper half acts as prescaler for the lower half
        if (advCh)
        begin
          clrHi = matchHi;
          incHi = !matchHi;
          if (matchHi)
          begin
            evLo = matchLo;
            clrLo = matchLo && contLo;
            incLo = !matchLo;
          end
        end
      end
      timer_watchdog_pkg::ARR_UNCHAINED:
      begin
        if (advLo)
        begin
          evLo = matchLo;
          clrLo = matchLo && contLo;
          incLo = !matchLo;
        end
        if (advHi)
        begin
          evHi = matchHi;
          clrHi = matchHi && contHi;
          incHi = !matchHi;
        end
      end
    endcase
    // timeout resets the timer; activation clears counters
    if (wdService || toEntry
        || (keyWr && wdState_q == timer_watchdog_pkg::WD_PREACTIVE
            && key == `KEY_SECOND && armNew))
    begin
      clrLo = 1'b1;
      clrHi = 1'b1;
      incLo = 1'b0;
      incHi = 1'b0;
    end
  end

  count_half #(.W(W)) u_low (
    .mclk(mclk),
    .rstn(resetN),
    .clr(clrLo),
    .load(regWr.en && regWr.sel == timer_watchdog_pkg::SEL_CNT_LO && wrCntOk),
    .loadData(regWr.data[W-1:0]),
    .inc(incLo),
    .count_q(counterLow)
  );

  count_half #(.W(W)) u_high (
    .mclk(mclk),
    .rstn(resetN),
    .clr(clrHi),
    .load(regWr.en && regWr.sel == timer_watchdog_pkg::SEL_CNT_HI && wrCntOk),
    .loadData(regWr.data[W-1:0]),
    .inc(incHi),
    .count_q(counterHigh)
  );

  // period writes dropped while running or locked
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
    begin
      prdLo_q <= '0;
      prdHi_q <= '0;
    end
    else if (regWr.en && wrCntOk)
    begin
      if (regWr.sel == timer_watchdog_pkg::SEL_PRD_LO)
        prdLo_q <= regWr.data[W-1:0];
      if (regWr.sel == timer_watchdog_pkg::SEL_PRD_HI)
        prdHi_q <= regWr.data[W-1:0];
    end
  end

  // running timer keeps only the run select fields
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      ctl_q <= `REG_RESET;
    else if (regWr.en && regWr.sel == timer_watchdog_pkg::SEL_CTL)
      ctl_q <= gpActive ? ((ctl_q & ~`CTL_RUN_MASK) | (regWr.data & `CTL_RUN_MASK))
               : regWr.data;
  end

  // running timer keeps only the release bits
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      glb_q <= `REG_RESET;
    else if (regWr.en && regWr.sel == timer_watchdog_pkg::SEL_GLB)
      glb_q <= gpActive ? ((glb_q & ~`GLB_REL_MASK) | (regWr.data & `GLB_REL_MASK))
               : regWr.data;
  end

  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      emu_q <= 2'h0;
    else if (regWr.en && regWr.sel == timer_watchdog_pkg::SEL_EMU)
      emu_q <= regWr.data[1:0];
  end

  // one-shot done flags; leaving one-shot run select re-arms them
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
    begin
      onceLo_q <= 1'b0;
      onceHi_q <= 1'b0;
    end
    else
    begin
      onceLo_q <= !contLo && (onceLo_q || evLo);
      onceHi_q <= !contHi && (onceHi_q || evHi);
    end
  end

  // disarmed at reset; no write disarms once active
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      arm_q <= 1'b0;
    else if (toEntry || wdState_q == timer_watchdog_pkg::WD_TIMEOUT)
      arm_q <= 1'b0;
    else if (keyWr && wdState_q == timer_watchdog_pkg::WD_INITIAL)
      arm_q <= armNew;
    // pre-active takes control only with a valid key
    else if (keyWr && wdState_q == timer_watchdog_pkg::WD_PREACTIVE
             && (key == `KEY_FIRST || key == `KEY_SECOND))
      arm_q <= armNew;
  end

  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      wdState_q <= timer_watchdog_pkg::WD_INITIAL;
    else
    begin
      unique case (wdState_q)
        timer_watchdog_pkg::WD_INITIAL:
        begin
          // arm and first key in watchdog arrangement
          if (keyWr && wdMode && armNew && key == `KEY_FIRST)
            wdState_q <= timer_watchdog_pkg::WD_PREACTIVE;
        end
        timer_watchdog_pkg::WD_PREACTIVE:
        begin
          // second key with arm set goes active
          if (keyWr && key == `KEY_SECOND && armNew)
            wdState_q <= timer_watchdog_pkg::WD_ACTIVE;
        end
        timer_watchdog_pkg::WD_ACTIVE:
        begin
          if (toEntry)
            wdState_q <= timer_watchdog_pkg::WD_TIMEOUT;
        end
        timer_watchdog_pkg::WD_TIMEOUT:
        begin
          wdState_q <= timer_watchdog_pkg::WD_TIMEOUT;
        end
      endcase
    end
  end

  // remember the first key of the pair
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      keySeen_q <= 1'b0;
    else if (keyWr && wdRun)
      keySeen_q <= (key == `KEY_FIRST);
  end

  // timeout holds the processor reset request
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      systemReset_q <= 1'b0;
    else if (toEntry)
      systemReset_q <= 1'b1;
  end

  // lower events for 64/chained/plain half, upper only for the unchained upper half
  always_ff @(posedge mclk or negedge resetN)
  begin
    if (!resetN)
      events_q <= '0;
    else
    begin
      events_q.irqLo <= evLo && !wdMode;
      events_q.dmaLo <= evLo && !wdMode;
      events_q.irqHi <= evHi;
      events_q.dmaHi <= evHi;
      events_q.wdIrq <= toEntry;
    end
  end

  // upper output falls back to lower settings here
  always_comb
  begin
    if (mode == timer_watchdog_pkg::ARR_64 || mode == timer_watchdog_pkg::ARR_UNCHAINED)
    begin
      hiWidth = ctl_q[`CTL_PW_LSB +: 2];
      hiInv = ctl_q[`CTL_INV_BIT];
      hiStyle = ctl_q[`CTL_STYLE_BIT];
    end
    else
    begin
      hiWidth = ctl_q[`CTL_HI_OFS + `CTL_PW_LSB +: 2];
      hiInv = ctl_q[`CTL_HI_OFS + `CTL_INV_BIT];
      hiStyle = ctl_q[`CTL_HI_OFS + `CTL_STYLE_BIT];
    end
  end
  assign hiTrig = wdMode ? toEntry : evHi;

  // pulse of width+1 clocks or toggle per match
  pulse_shaper u_out_low (
    .mclk(mclk),
    .rstn(resetN),
    .trig(evLo && !wdMode),
    .width(ctl_q[`CTL_PW_LSB +: 2]),
    .invert(ctl_q[`CTL_INV_BIT]),
    .clockMode(ctl_q[`CTL_STYLE_BIT]),
    .pinOut_q(timerOutLow)
  );

  pulse_shaper u_out_high (
    .mclk(mclk),
    .rstn(resetN),
    .trig(hiTrig),
    .width(hiWidth),
    .invert(hiInv),
    .clockMode(hiStyle),
    .pinOut_q(timerOutHigh)
  );

  assign wdState = wdState_q;
  assign watchdogArm = arm_q;
endmodule : timer_watchdog_core
`default_nettype wire

// ==== test/timer_watchdog_core_asserts.sv ====
// Purpose: port checks for the timer/watchdog core
// Assumes: state, arm and events come from flops
// Notes: bound onto every core instance
`timescale 1ns/100ps
`default_nettype none
`include "timer_watchdog_defs.svh"
module timer_watchdog_core_asserts #(
  parameter bit IS_WATCHDOG = 1'b1,
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psuResetN,
  input wire timer_watchdog_pkg::reg_wr_t regWr,
  input wire logic debugSuspend,
  input wire logic [W-1:0] counterLow,
  input wire logic [W-1:0] counterHigh,
  input wire timer_watchdog_pkg::wd_state_t wdState,
  input wire logic watchdogArm,
  input wire logic systemReset_q,
  input wire timer_watchdog_pkg::events_t events_q,
  input wire logic timerOutLow,
  input wire logic timerOutHigh
);
  logic isIni;
  logic isPre;
  logic isAct;
  logic isTo;
  logic keyWr;
  logic firstKey;
  logic badKey;
  assign isIni = wdState == timer_watchdog_pkg::WD_INITIAL;
  assign isPre = wdState == timer_watchdog_pkg::WD_PREACTIVE;
  assign isAct = wdState == timer_watchdog_pkg::WD_ACTIVE;
  assign isTo = wdState == timer_watchdog_pkg::WD_TIMEOUT;
  assign keyWr = regWr.en && regWr.sel == timer_watchdog_pkg::SEL_WDC;
  assign firstKey = keyWr && regWr.data[31:16] == `KEY_FIRST;
  // any key other than the two valid ones is a failed service
  assign badKey = keyWr && regWr.data[31:16] != `KEY_FIRST
    && regWr.data[31:16] != `KEY_SECOND;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!(rstn && psuResetN));
  a_reset_sticky: assert property (systemReset_q |=> systemReset_q)
    else $error("reset request dropped");
  a_timeout_holds: assert property (isTo |=> isTo)
    else $error("timeout state left");
  a_timeout_disarm: assert property (isTo [*2] |-> !watchdogArm)
    else $error("arm set in timeout");
  a_active_holds: assert property (isAct |=> isAct || isTo)
    else $error("active watchdog turned off");
  a_pre_entry: assert property (isIni ##1 isPre |-> $past(firstKey))
    else $error("pre-active without first key");
  a_bad_key: assert property (isAct && badKey |=> isTo)
    else $error("wrong key did not time out");
  a_activate_clear: assert property (isPre ##1 isAct |-> counterHigh == 0 && counterLow < 2)
    else $error("counters not cleared on activation");
  a_irq_resets: assert property (events_q.wdIrq |-> ##[0:1] systemReset_q)
    else $error("watchdog interrupt without reset");
  a_wd_quiet: assert property (!isIni |-> !events_q.dmaLo && !events_q.dmaHi && !events_q.irqLo)
    else $error("timer event in watchdog mode");
  a_gp_pairs: assert property (!IS_WATCHDOG |-> events_q.irqLo == events_q.dmaLo
    && events_q.irqHi == events_q.dmaHi && !events_q.wdIrq && !systemReset_q)
    else $error("event pairing wrong");
  c_active: cover property (isAct);
  c_wd_irq: cover property (events_q.wdIrq);
  c_pulse: cover property (events_q.irqLo ##1 timerOutLow);
endmodule : timer_watchdog_core_asserts
bind timer_watchdog_core timer_watchdog_core_asserts #(.IS_WATCHDOG(IS_WATCHDOG), .W(W)) chk (
  .mclk(mclk), .rstn(rstn), .psuResetN(psuResetN), .regWr(regWr),
  .debugSuspend(debugSuspend), .counterLow(counterLow), .counterHigh(counterHigh),
  .wdState(wdState), .watchdogArm(watchdogArm), .systemReset_q(systemReset_q),
  .events_q(events_q), .timerOutLow(timerOutLow), .timerOutHigh(timerOutHigh)
);
`default_nettype wire

// ==== test/host_bus_model.sv ====
// Purpose: processor side issuing one-cycle register writes
// Assumes: the core takes a write on the edge where en is high
// Notes: idle data is inverted so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
  input wire logic mclk,
  output var timer_watchdog_pkg::reg_wr_t regWr
);
  initial regWr = '0;
  task automatic wr(input timer_watchdog_pkg::reg_sel_t s, input logic [31:0] d);
    @(posedge mclk);
    regWr <= '{en: 1'b1, sel: s, data: d};
    @(posedge mclk);
    regWr <= '{en: 1'b0, sel: s, data: ~d};
    #1;
  endtask : wr
endmodule : host_bus_model
`default_nettype wire

// ==== test/tb_timer_watchdog_core.sv ====
// Purpose: self-checking bench, watchdog instance and general-purpose instance
// Assumes: writes go through host_bus_model
// Notes: table rows set up the general timer, hand tests follow
`timescale 1ns/100ps
`default_nettype none
module tb_timer_watchdog_core;
  typedef struct {
    timer_watchdog_pkg::reg_sel_t sel;
    logic [31:0] data;
    logic [31:0] expLow;
  } row_t;
  logic mclk, rstn, psuResetN, debugSuspend, wdArm, wdRst, gpOut;
  logic [31:0] wdLow, wdHigh, gpLow, v;
  timer_watchdog_pkg::reg_wr_t wdWr, gpWr;
  timer_watchdog_pkg::wd_state_t wdSt;
  timer_watchdog_pkg::events_t wdEv, gpEv;
  int n_errors, cmp_count, hi, irq, zero, n;
  row_t rows[4];
  host_bus_model wd (.mclk(mclk), .regWr(wdWr));
  host_bus_model gp (.mclk(mclk), .regWr(gpWr));
  timer_watchdog_core #(.IS_WATCHDOG(1'b1), .W(32)) uut (.mclk(mclk), .rstn(rstn),
    .psuResetN(psuResetN), .regWr(wdWr), .debugSuspend(debugSuspend), .counterLow(wdLow),
    .counterHigh(wdHigh), .wdState(wdSt), .watchdogArm(wdArm), .systemReset_q(wdRst),
    .events_q(wdEv), .timerOutLow(), .timerOutHigh());
  timer_watchdog_core #(.IS_WATCHDOG(1'b0), .W(32)) uutGp (.mclk(mclk), .rstn(rstn),
    .psuResetN(psuResetN), .regWr(gpWr), .debugSuspend(debugSuspend), .counterLow(gpLow),
    .counterHigh(), .wdState(), .watchdogArm(), .systemReset_q(),
    .events_q(gpEv), .timerOutLow(gpOut), .timerOutHigh());
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic test_done;
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic wdStart;
    wd.wr(timer_watchdog_pkg::SEL_PRD_LO, 32'h0000_0040);
    wd.wr(timer_watchdog_pkg::SEL_GLB, 32'h0000_000b); // global set before arming
    wd.wr(timer_watchdog_pkg::SEL_CTL, 32'h0030_0080);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'h0000_4000);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'ha5c6_4000);
  endtask : wdStart
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // run should finish in well under a thousand cycles
  initial
  begin
    #50000;
    n_errors++;
    test_done();
  end
  initial
  begin
    rstn = 1'b0;
    psuResetN = 1'b1;
    debugSuspend = 1'b0;
    rows = '{'{timer_watchdog_pkg::SEL_CNT_LO, 32'hffff_fffe, 32'hffff_fffe},
      '{timer_watchdog_pkg::SEL_CNT_HI, 32'h0000_0000, 32'hffff_fffe},
      '{timer_watchdog_pkg::SEL_PRD_LO, 32'h0000_0001, 32'hffff_fffe},
      '{timer_watchdog_pkg::SEL_GLB, 32'h0000_0007, 32'hffff_fffe}};
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk("wdState", 32'h0, 32'(wdSt));
    chk("wdArm", 32'h0, 32'(wdArm));
    chk("wdRst", 32'h0, 32'(wdRst));
    chk("gpLow", 32'h0, gpLow);
    foreach (rows[i])
    begin
      gp.wr(rows[i].sel, rows[i].data);
      chk("rowLow", rows[i].expLow, gpLow);
    end
    // one-shot run from above the period, pulse width three clocks
    gp.wr(timer_watchdog_pkg::SEL_CTL, 32'h0000_0060);
    for (int i = 0; i < 14; i++)
    begin
      @(posedge mclk);
      #1;
      zero += int'(gpLow === 32'h0);
      irq += int'(gpEv.irqLo === 1'b1);
      hi += int'(gpOut === 1'b1);
      chk("gpIrqHi", 32'h0, 32'(gpEv.irqHi));
    end
    chk("gpWrap", 32'h1, 32'(zero > 0));
    chk("gpStop", 32'h1, gpLow);
    chk("gpIrqCount", 32'h1, 32'(irq));
    chk("gpPulse", 32'h3, 32'(hi));
    gp.wr(timer_watchdog_pkg::SEL_CNT_LO, 32'h0000_0010);
    chk("gpLocked", 32'h1, gpLow);
    gp.wr(timer_watchdog_pkg::SEL_GLB, 32'h0000_0004);
    gp.wr(timer_watchdog_pkg::SEL_CTL, 32'h0000_0080);
    repeat (3) @(posedge mclk);
    #1;
    chk("gpFrozen", 32'h1, gpLow);
    gp.wr(timer_watchdog_pkg::SEL_EMU, 32'h0000_0000);
    gp.wr(timer_watchdog_pkg::SEL_GLB, 32'h0000_0007);
    @(posedge mclk);
    debugSuspend <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    v = gpLow;
    repeat (3) @(posedge mclk);
    #1;
    chk("gpHalted", v, gpLow);
    gp.wr(timer_watchdog_pkg::SEL_EMU, 32'h0000_0001);
    v = gpLow;
    @(posedge mclk);
    #1;
    chk("gpFreeRun", 32'h1, 32'(gpLow !== v));
    @(posedge mclk);
    debugSuspend <= 1'b0;
    // clock style: period 1 gives a match every other cycle, so half of 8 samples high
    gp.wr(timer_watchdog_pkg::SEL_GLB, 32'h0000_0004);
    gp.wr(timer_watchdog_pkg::SEL_CTL, 32'h0000_0088);
    gp.wr(timer_watchdog_pkg::SEL_GLB, 32'h0000_0007);
    hi = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      hi += int'(gpOut === 1'b1);
    end
    chk("gpClock", 32'h4, 32'(hi));
    wdStart();
    chk("wdPre", 32'h1, 32'(wdSt));
    wd.wr(timer_watchdog_pkg::SEL_CNT_HI, 32'h0000_0005);
    chk("wdHighLocked", 32'h0, wdHigh);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'h0000_0000);
    chk("wdArmKept", 32'h1, 32'(wdArm));
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'hda7e_4000);
    chk("wdActive", 32'h2, 32'(wdSt));
    chk("wdCleared", 32'h1, 32'(wdLow < 2 && wdHigh == 0));
    repeat (20) @(posedge mclk);
    // arm bit left low on purpose: software must not be able to disarm
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'ha5c6_0000);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'hda7e_0000);
    chk("wdServiced", 32'h1, 32'(wdLow < 3));
    chk("wdStillArmed", 32'h1, 32'(wdArm));
    n = 0;
    while (wdEv.wdIrq !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("wdSpan", 32'h1, 32'(n > 55 && n < 100));
    @(posedge mclk);
    #1;
    chk("wdRst", 32'h1, 32'(wdRst));
    chk("wdTimeout", 32'h3, 32'(wdSt));
    chk("wdLowReset", 32'h0, wdLow);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'h0000_4000);
    chk("wdArmDead", 32'h0, 32'(wdArm));
    @(posedge mclk);
    psuResetN <= 1'b0;
    @(posedge mclk);
    psuResetN <= 1'b1;
    #1;
    chk("psuRst", 32'h0, 32'(wdRst));
    chk("psuState", 32'h0, 32'(wdSt));
    wdStart();
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'hda7e_4000);
    wd.wr(timer_watchdog_pkg::SEL_WDC, 32'h1234_4000);
    chk("wdBadKey", 32'h3, 32'(wdSt));
    @(posedge mclk);
    #1;
    chk("wdBadRst", 32'h1, 32'(wdRst));
    test_done();
  end
endmodule : tb_timer_watchdog_core
`default_nettype wire
